/* File: core/tcs_timer_dev.sv */
`timescale 1ns/1ps
`default_nettype none
//Contract
// - overflow irq = overflow flag and bit4
// - underflow enable bit5 only channels 1,2
// - enables 3,2 only in channel 0
// - enables 1,0 gate gen B/A irqs
// - direction flag bit7, channels 1,2 only
// - underflow flag on 0000 to FFFF
// - overflow flag on FFFF to 0000
// - flag clears by zero after read one
// - software clears flags by writing zero
// - compare match sets gen event flag
// - capture copies counter, sets event flag
// - gen C/D flags only channel 0
// - three 16-bit counters reset to 0000
// - gen registers reset to FFFF
// - channel 0: C buffers A, D buffers B
// - run bits gate counters, upper bits zero
// - stop counter before mode/clock change
// - stop holds compare pin level
// - pin config write while stopped sets level
// - sync bit: counter write presets all synced
// - sync clear needs clear source selected
// - counters, gen registers word access only
// - byte registers take byte or word access
module tcs_timer_dev (
    input wire logic ref_clk,
    input wire logic rstn,
    tcs_bus_if.dev bus,
    input wire logic [2:0] count_tick,
    input wire logic [2:0] phase_mode,
    input wire logic [2:0] count_down,
    input wire logic [11:0] gen_is_capture,
    input wire logic [23:0] gen_action,
    input wire logic [5:0] clear_sel,
    input wire logic buf_a_en,
    input wire logic buf_b_en,
    input wire logic [11:0] capture_pin,
    input wire logic [11:0] pin_cfg_wr,
    input wire logic [11:0] pin_init_level,
    output logic [11:0] timer_io_pin,
    output logic [2:0] overflow_irq,
    output logic [2:0] underflow_irq,
    output logic [2:0] gen_a_irq,
    output logic [2:0] gen_b_irq,
    output logic [2:0] gen_c_irq,
    output logic [2:0] gen_d_irq
);
    logic [2:0] run_q;
    logic [7:0] sync_q;
    logic [15:0] rdata_q;
    logic [11:0] pin_s1_q;
    logic [11:0] pin_s2_q;
    logic [11:0] pin_s3_q;
    logic [15:0] cnt_w [3];
    logic [15:0] gen_w [3][4];
    logic [7:0] ier_w [3];
    logic [7:0] sr_w [3];
    logic [2:0] clr_ev;
    logic [1:0] acc_ch;
    logic [2:0] acc_ofs;
    logic glob_hit;
    logic word_ok;
    logic [2:0] cnt_wr;
    logic [2:0] sync_load;

    assign acc_ch = bus.addr[4:3];
    assign acc_ofs = bus.addr[2:0];
    assign glob_hit = (bus.addr == tcs_pkg::ADDR_RUN_SYNC);
    assign word_ok = (bus.be == tcs_pkg::BE_WORD);
    assign bus.rdata = rdata_q;

    // capture pins come from outside: two flops before any use
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_q <= 12'h000;
            pin_s2_q <= 12'h000;
            pin_s3_q <= 12'h000;
        end else begin
            pin_s1_q <= capture_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // byte lanes of the run/sync word are separate registers: 3 run bits in the high byte, 8 sync bits in the low byte
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            run_q <= 3'h0;
            sync_q <= tcs_pkg::SYNC_RST;
        end else if (bus.wr && glob_hit) begin
            if (bus.be[1]) begin
                run_q <= bus.wdata[10:8] & tcs_pkg::RUN_MASK;
            end
            if (bus.be[0]) begin
                sync_q <= bus.wdata[7:0];
            end
        end
    end

    // a bus write to a synchronized counter presets every synchronized counter; other writes load only their own counter
    always_comb begin
        for (int k = 0; k < tcs_pkg::NCH; k++) begin
            cnt_wr[k] = bus.wr && word_ok && !glob_hit && (acc_ch == 2'(k))
                && (acc_ofs == tcs_pkg::OFS_CNT);
        end
        for (int k = 0; k < tcs_pkg::NCH; k++) begin
            sync_load[k] = cnt_wr[k] || (sync_q[k] && |(cnt_wr & sync_q[2:0]));
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 16'h0000;
        end else if (bus.rd) begin
            if (glob_hit) begin
                rdata_q <= {5'h00, run_q, sync_q};
            end else if (acc_ch == 2'h3) begin
                rdata_q <= 16'h0000;
            end else if (acc_ofs == tcs_pkg::OFS_IER_SR) begin
                rdata_q <= {ier_w[acc_ch], sr_w[acc_ch]};
            end else if (acc_ofs == tcs_pkg::OFS_CNT) begin
                rdata_q <= cnt_w[acc_ch];
            end else if (acc_ofs >= tcs_pkg::OFS_GEN_A && acc_ofs <= 3'h5) begin
                rdata_q <= gen_w[acc_ch][2'(acc_ofs - tcs_pkg::OFS_GEN_A)];
            end else begin
                rdata_q <= 16'h0000;
            end
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_ch
        localparam int NG = (g == 0) ? 4 : 2;
        localparam logic [5:0] FMASK = (g == 0) ? tcs_pkg::MASK_CH0 : tcs_pkg::MASK_CH12;
        logic [15:0] cnt_q;
        logic [15:0] gen_q [4];
        logic [5:0] flag_q;
        logic [5:0] armed_q;
        logic [6:0] ier_q;
        logic [3:0] pin_q;
        logic [5:0] irq_q;
        logic tick;
        logic down;
        logic ovf;
        logic unf;
        logic self_clr;
        logic do_clr;
        logic sr_rd;
        logic sr_wr;
        logic ier_wr;
        logic [3:0] gen_wr;
        logic [3:0] is_buf;
        logic [3:0] match;
        logic [3:0] cap;
        logic [5:0] set_ev;
        logic [5:0] clr_req;

        assign tick = count_tick[g] && run_q[g];
        assign down = (g != 0) && phase_mode[g] && count_down[g];
        assign ovf = tick && !down && (cnt_q == tcs_pkg::CNT_MAX);
        assign unf = tick && down && (cnt_q == tcs_pkg::CNT_RST);
        assign sr_rd = bus.rd && !glob_hit && (acc_ch == 2'(g)) && (acc_ofs == tcs_pkg::OFS_IER_SR);
        assign sr_wr = bus.wr && !glob_hit && (acc_ch == 2'(g))
            && (acc_ofs == tcs_pkg::OFS_IER_SR) && bus.be[0];
        assign ier_wr = bus.wr && !glob_hit && (acc_ch == 2'(g))
            && (acc_ofs == tcs_pkg::OFS_IER_SR) && bus.be[1];
        assign is_buf = (g == 0) ? {buf_b_en, buf_a_en, 2'h0} : 4'h0;

        for (genvar j = 0; j < 4; j++) begin : g_slot
            if (j < NG) begin : g_on
                logic [1:0] act;
                logic rise;
                logic fall;
                assign act = gen_action[g*8+j*2 +: 2];
                assign rise = pin_s2_q[g*4+j] && !pin_s3_q[g*4+j];
                assign fall = !pin_s2_q[g*4+j] && pin_s3_q[g*4+j];
                assign match[j] = tick && !gen_is_capture[g*4+j] && !is_buf[j]
                    && (cnt_q == gen_q[j]);
                assign cap[j] = gen_is_capture[g*4+j] && !is_buf[j]
                    && ((act[0] && rise) || (act[1] && fall));
                assign gen_wr[j] = bus.wr && word_ok && !glob_hit && (acc_ch == 2'(g))
                    && (acc_ofs == 3'(j + 2));
                always_ff @(posedge ref_clk or negedge rstn) begin
                    if (!rstn) begin
                        pin_q[j] <= 1'b0;
                    end else if (pin_cfg_wr[g*4+j] && !run_q[g]) begin
                        pin_q[j] <= pin_init_level[g*4+j];
                    end else if (match[j]) begin
                        // a stopped counter makes no match, so the level holds
                        case (act)
                            tcs_pkg::ACT_LOW: pin_q[j] <= 1'b0;
                            tcs_pkg::ACT_HIGH: pin_q[j] <= 1'b1;
                            tcs_pkg::ACT_TOGGLE: pin_q[j] <= !pin_q[j];
                            default: pin_q[j] <= pin_q[j];
                        endcase
                    end
                end
            end else begin : g_off
                assign match[j] = 1'b0;
                assign cap[j] = 1'b0;
                assign gen_wr[j] = 1'b0;
                assign pin_q[j] = 1'b0;
            end
        end

        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                // absent slots of channels 1 and 2 sit at zero so they read 0
                for (int j = 0; j < 4; j++) begin
                    gen_q[j] <= (j < NG) ? tcs_pkg::GEN_RST : 16'h0000;
                end
            end else begin
                for (int j = 0; j < 4; j++) begin
                    if (gen_wr[j]) begin
                        gen_q[j] <= bus.wdata;
                    end else if (cap[j]) begin
                        gen_q[j] <= cnt_q;
                    end else if (j < 2 && is_buf[j+2] && match[j]) begin
                        gen_q[j] <= gen_q[j+2];
                    end else if (j >= 2 && is_buf[j] && cap[j-2]) begin
                        gen_q[j] <= gen_q[j-2];
                    end
                end
            end
        end

        assign clr_ev[g] = (clear_sel[g*2 +: 2] == tcs_pkg::CLR_GEN_A && (match[0] || cap[0]))
            || (clear_sel[g*2 +: 2] == tcs_pkg::CLR_GEN_B && (match[1] || cap[1]));
        // sync clear follows any other synchronized channel's own clear
        assign self_clr = (clear_sel[g*2 +: 2] == tcs_pkg::CLR_SYNC) && sync_q[g]
            && |(clr_ev & sync_q[2:0] & ~(3'h1 << g));
        assign do_clr = clr_ev[g] || self_clr;

        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                cnt_q <= tcs_pkg::CNT_RST;
            end else if (sync_load[g]) begin
                cnt_q <= bus.wdata;
            end else if (do_clr) begin
                cnt_q <= tcs_pkg::CNT_RST;
            end else if (tick) begin
                cnt_q <= down ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
            end
        end

        assign set_ev = {unf, ovf, match | cap} & FMASK;
        assign clr_req = sr_wr ? (armed_q & ~bus.wdata[5:0]) : 6'h00;

        // set wins over a clear in the same cycle
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                flag_q <= 6'h00;
                armed_q <= 6'h00;
            end else begin
                flag_q <= (flag_q & ~clr_req) | set_ev;
                if (sr_rd) begin
                    armed_q <= flag_q;
                end else begin
                    armed_q <= armed_q & ~clr_req;
                end
            end
        end

        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                ier_q <= 7'h00;
            end else if (ier_wr) begin
                ier_q <= {bus.wdata[15], bus.wdata[13:8] & FMASK};
            end
        end

        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                irq_q <= 6'h00;
            end else begin
                irq_q <= flag_q & ier_q[5:0];
            end
        end

        assign ier_w[g] = {ier_q[6], 1'b1, ier_q[5:0]};
        assign sr_w[g] = {(g != 0) && !down, 1'b1, flag_q};
        assign cnt_w[g] = cnt_q;
        for (genvar j = 0; j < 4; j++) begin : g_exp
            assign gen_w[g][j] = gen_q[j];
        end
        assign timer_io_pin[g*4 +: 4] = pin_q;
        assign overflow_irq[g] = irq_q[tcs_pkg::BIT_OVF];
        assign underflow_irq[g] = irq_q[tcs_pkg::BIT_UNF];
        assign gen_a_irq[g] = irq_q[tcs_pkg::BIT_GEN_A];
        assign gen_b_irq[g] = irq_q[tcs_pkg::BIT_GEN_B];
        assign gen_c_irq[g] = irq_q[tcs_pkg::BIT_GEN_C];
        assign gen_d_irq[g] = irq_q[tcs_pkg::BIT_GEN_D];
    end
endmodule
`default_nettype wire

/* File: core/tcs_pkg.sv */
package tcs_pkg;
    localparam int NCH = 3;
    localparam int NSLOT = 4;
    localparam int AW = 5;
    localparam int DW = 16;
    // word map: channel c at c*CH_STRIDE, global word after the channels
    localparam logic [1:0] CH_STRIDE_SH = 2'h3;
    localparam logic [2:0] OFS_IER_SR = 3'h0;
    localparam logic [2:0] OFS_CNT = 3'h1;
    localparam logic [2:0] OFS_GEN_A = 3'h2;
    localparam logic [4:0] ADDR_RUN_SYNC = 5'h18;
    // enable register (high byte) and status register (low byte) fields
    localparam int BIT_ADC_EN = 7;
    localparam int BIT_FIXED_ONE = 6;
    localparam int BIT_UNF = 5;
    localparam int BIT_OVF = 4;
    localparam int BIT_GEN_D = 3;
    localparam int BIT_GEN_C = 2;
    localparam int BIT_GEN_B = 1;
    localparam int BIT_GEN_A = 0;
    localparam int BIT_DIR = 7;
    localparam logic [5:0] MASK_CH0 = 6'h1F;
    localparam logic [5:0] MASK_CH12 = 6'h33;
    localparam logic [2:0] RUN_MASK = 3'h7;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] GEN_RST = 16'hFFFF;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [7:0] SYNC_RST = 8'h00;
    localparam logic [1:0] BE_WORD = 2'h3;
    localparam logic [1:0] BE_LO = 2'h1;
    localparam logic [1:0] BE_HI = 2'h2;
    // compare actions; in capture mode the same code picks the edge
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_GEN_A = 2'h1;
    localparam logic [1:0] CLR_GEN_B = 2'h2;
    localparam logic [1:0] CLR_SYNC = 2'h3;
    typedef enum logic [2:0] {H_IDLE, H_RD, H_RD_DATA, H_CLR_RD, H_CLR_DATA, H_CLR_WR} tcs_hstate_t;
endpackage

/* File: core/tcs_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tcs_bus_if;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    modport dev (input addr, input wdata, input be, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output be, output wr, output rd, input rdata);
endinterface
`default_nettype wire

/* File: core/tcs_timer_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tcs_timer_host (
    input wire logic ref_clk,
    input wire logic rstn,
    tcs_bus_if.host bus,
    input wire logic [4:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    input wire logic [1:0] cmd_be,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic cmd_clr,
    output logic [15:0] resp_data,
    output logic resp_valid,
    output logic busy
);
    tcs_pkg::tcs_hstate_t state_q;
    logic [4:0] addr_q;
    logic [15:0] wdata_q;
    logic [1:0] be_q;
    logic wr_q;
    logic rd_q;
    logic [5:0] mask_q;
    logic word_reg;

    // counters and gen registers are never split into bytes
    assign word_reg = (cmd_addr != tcs_pkg::ADDR_RUN_SYNC) && (cmd_addr[2:0] != 3'h0);
    assign bus.addr = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.be = be_q;
    assign bus.wr = wr_q;
    assign bus.rd = rd_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= tcs_pkg::H_IDLE;
            addr_q <= 5'h00;
            wdata_q <= 16'h0000;
            be_q <= 2'h0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            mask_q <= 6'h00;
            resp_data <= 16'h0000;
            resp_valid <= 1'b0;
            busy <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            resp_valid <= 1'b0;
            case (state_q)
                tcs_pkg::H_IDLE: begin
                    addr_q <= cmd_addr;
                    be_q <= word_reg ? tcs_pkg::BE_WORD : cmd_be;
                    wdata_q <= cmd_wdata;
                    mask_q <= cmd_wdata[5:0];
                    if (cmd_clr) begin
                        addr_q <= {cmd_addr[4:3], tcs_pkg::OFS_IER_SR};
                        be_q <= tcs_pkg::BE_LO;
                        rd_q <= 1'b1;
                        busy <= 1'b1;
                        state_q <= tcs_pkg::H_CLR_RD;
                    end else if (cmd_wr) begin
                        wr_q <= 1'b1;
                    end else if (cmd_rd) begin
                        rd_q <= 1'b1;
                        busy <= 1'b1;
                        state_q <= tcs_pkg::H_RD;
                    end
                end
                tcs_pkg::H_RD: state_q <= tcs_pkg::H_RD_DATA;
                tcs_pkg::H_RD_DATA: begin
                    resp_data <= bus.rdata;
                    resp_valid <= 1'b1;
                    busy <= 1'b0;
                    state_q <= tcs_pkg::H_IDLE;
                end
                tcs_pkg::H_CLR_RD: state_q <= tcs_pkg::H_CLR_DATA;
                tcs_pkg::H_CLR_DATA: begin
                    // zeros only on the chosen flags; ones elsewhere leave flags alone
                    wdata_q <= {8'h00, 2'h3, ~mask_q};
                    resp_data <= bus.rdata;
                    wr_q <= 1'b1;
                    state_q <= tcs_pkg::H_CLR_WR;
                end
                tcs_pkg::H_CLR_WR: begin
                    resp_valid <= 1'b1;
                    busy <= 1'b0;
                    state_q <= tcs_pkg::H_IDLE;
                end
                default: state_q <= tcs_pkg::H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: tb/tcs_bus_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module tcs_bus_sva (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [4:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [1:0] be,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence ctl_rd(logic [1:0] ch);
        rd && addr[4:3] == ch && addr[2:0] == 3'h0;
    endsequence
    // channels 1 and 2 only; the global word sits at channel index 3
    sequence ch12_rd(logic [2:0] ofs);
        rd && (addr[4:3] == 2'h1 || addr[4:3] == 2'h2) && addr[2:0] == ofs;
    endsequence

    strobe_excl_a: assert property (!(wr && rd))
        else $error("write and read strobes together");
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside read answer");
    word_access_a: assert property (
        wr && addr < 5'h18 && addr[2:0] inside {[3'h1:3'h5]} |-> be == 2'h3)
        else $error("counter or general register written by bytes");
    ch0_unf_a: assert property (ctl_rd(2'h0) |=> rdata[13] == 1'b0 && rdata[5] == 1'b0)
        else $error("channel 0 underflow bits not zero");
    ch0_dir_a: assert property (ctl_rd(2'h0) |=> rdata[7] == 1'b0)
        else $error("channel 0 direction bit not zero");
    ch12_en_cd_a: assert property (ch12_rd(3'h0) |=> rdata[11:10] == 2'h0)
        else $error("channel 1 or 2 enables C D not zero");
    ch12_flag_cd_a: assert property (ch12_rd(3'h0) |=> rdata[3:2] == 2'h0)
        else $error("channel 1 or 2 flags C D not zero");
    run_upper_a: assert property (rd && addr == 5'h18 |=> rdata[15:11] == 5'h00)
        else $error("run register upper bits not zero");
    fixed_one_a: assert property (rd && addr < 5'h18 && addr[2:0] == 3'h0
        |=> rdata[14] && rdata[6])
        else $error("fixed one bits not set");
    ch12_gen_cd_a: assert property (ch12_rd(3'h4) or ch12_rd(3'h5) |=> rdata == 16'h0000)
        else $error("channel 1 or 2 slot C D not zero");
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] count_tick = 3'h7, phase_mode = 3'h0, count_down = 3'h0;
    logic [11:0] gen_is_capture = 12'h000, capture_pin = 12'h000;
    logic [11:0] pin_cfg_wr = 12'h000, pin_init_level = 12'h000;
    logic [23:0] gen_action = 24'h000000;
    logic [5:0] clear_sel = 6'h00;
    logic buf_a_en = 1'b0, buf_b_en = 1'b0;
    logic [11:0] timer_io_pin;
    logic [2:0] overflow_irq, underflow_irq, gen_a_irq, gen_b_irq, gen_c_irq, gen_d_irq;
    logic [4:0] cmd_addr = 5'h00;
    logic [15:0] cmd_wdata = 16'h0000;
    logic [1:0] cmd_be = 2'h0;
    logic cmd_wr = 1'b0, cmd_rd = 1'b0, cmd_clr = 1'b0;
    logic [15:0] resp_data;
    logic resp_valid, busy;
    int err_count = 0;
    int n_compared = 0;

    always #10 ref_clk = ~ref_clk;

    tcs_bus_if bus_i ();
    tcs_timer_dev tcs_timer_dev_inst (.ref_clk(ref_clk), .rstn(rstn), .bus(bus_i),
        .count_tick(count_tick), .phase_mode(phase_mode), .count_down(count_down),
        .gen_is_capture(gen_is_capture), .gen_action(gen_action), .clear_sel(clear_sel),
        .buf_a_en(buf_a_en), .buf_b_en(buf_b_en), .capture_pin(capture_pin),
        .pin_cfg_wr(pin_cfg_wr), .pin_init_level(pin_init_level), .timer_io_pin(timer_io_pin),
        .overflow_irq(overflow_irq), .underflow_irq(underflow_irq), .gen_a_irq(gen_a_irq),
        .gen_b_irq(gen_b_irq), .gen_c_irq(gen_c_irq), .gen_d_irq(gen_d_irq));
    tcs_timer_host tcs_timer_host_inst (.ref_clk(ref_clk), .rstn(rstn), .bus(bus_i),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_be(cmd_be), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_clr(cmd_clr), .resp_data(resp_data), .resp_valid(resp_valid),
        .busy(busy));
    tcs_bus_sva tcs_bus_sva_inst (.ref_clk(ref_clk), .rstn(rstn), .addr(bus_i.addr),
        .wdata(bus_i.wdata), .be(bus_i.be), .wr(bus_i.wr), .rd(bus_i.rd), .rdata(bus_i.rdata));

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bail(input string what);
        err_count++;
        $display("MISMATCH %s expected done seen timeout", what);
        give_verdict;
    endtask

    // k: 0 write, 1 read, 2 flag clear; reads an output at the edge, so it sees the settled value
    task automatic cmd(input int k, input logic [4:0] a, input logic [15:0] d,
        input logic [1:0] b, output logic [15:0] q);
        int i;
        i = 0;
        q = 16'h0000;
        @(posedge ref_clk);
        while (busy !== 1'b0 && i < 50) begin
            @(posedge ref_clk);
            i++;
        end
        if (i >= 50) bail("host_busy");
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_be <= b;
        cmd_wr <= (k == 0);
        cmd_rd <= (k == 1);
        cmd_clr <= (k == 2);
        @(posedge ref_clk);
        {cmd_wr, cmd_rd, cmd_clr} <= 3'h0;
        if (k != 0) begin
            i = 0;
            while (resp_valid !== 1'b1 && i < 50) begin
                @(posedge ref_clk);
                i++;
            end
            if (i >= 50) bail("host_resp");
            q = resp_data;
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [1:0] b);
        logic [15:0] q;
        cmd(0, a, d, b, q);
    endtask

    task automatic rchk(input string what, input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] q;
        cmd(1, a, 16'h0000, 2'h3, q);
        chk(what, exp, q);
    endtask

    task automatic s_reset;
        rchk("ch0_ctl", 5'h00, 16'h4040);
        rchk("ch1_ctl", 5'h08, 16'h40C0);
        rchk("ch2_cnt", 5'h11, 16'h0000);
        rchk("ch0_gen_d", 5'h05, 16'hFFFF);
        rchk("ch2_gen_b", 5'h13, 16'hFFFF);
        rchk("run_sync", 5'h18, 16'h0000);
        rchk("unmapped", 5'h1F, 16'h0000);
    endtask

    task automatic s_enable;
        for (int c = 0; c < 3; c++) begin
            wr(5'(c * 8), 16'hFF00, 2'h2);
        end
        rchk("ch0_en", 5'h00, 16'hDF40);
        rchk("ch1_en", 5'h08, 16'hF3C0);
        rchk("ch2_en", 5'h10, 16'hF3C0);
        wr(5'h18, 16'hFF00, 2'h2);
        rchk("run_bits", 5'h18, 16'h0700);
        wr(5'h18, 16'h0000, 2'h2);
    endtask

    task automatic s_overflow;
        logic [15:0] q;
        wr(5'h01, 16'hFFFD, 2'h3);
        wr(5'h18, 16'h0100, 2'h2);
        repeat (8) @(posedge ref_clk);
        wr(5'h18, 16'h0000, 2'h2);
        // zero write before any read of the set flags must not clear
        wr(5'h00, 16'h0000, 2'h1);
        rchk("ch0_wrap", 5'h00, 16'hDF5F);
        chk("irq_ch0", 16'h001F, {11'h000, overflow_irq[0], gen_a_irq[0], gen_b_irq[0],
            gen_c_irq[0], gen_d_irq[0]});
        cmd(2, 5'h00, 16'h0010, 2'h1, q);
        rchk("ch0_clr_ovf", 5'h00, 16'hDF4F);
        wr(5'h00, 16'h0000, 2'h1);
        rchk("ch0_clr_all", 5'h00, 16'hDF40);
        chk("irq_ch0_off", 16'h0000, {11'h000, overflow_irq[0], gen_a_irq[0], gen_b_irq[0],
            gen_c_irq[0], gen_d_irq[0]});
    endtask

    task automatic s_underflow;
        phase_mode <= 3'h2;
        count_down <= 3'h2;
        rchk("ch1_down", 5'h08, 16'hF340);
        wr(5'h09, 16'h0002, 2'h3);
        wr(5'h18, 16'h0200, 2'h2);
        repeat (8) @(posedge ref_clk);
        wr(5'h18, 16'h0000, 2'h2);
        rchk("ch1_unf", 5'h08, 16'hF363);
        chk("irq_ch1", 16'h000E, {12'h000, underflow_irq[1], gen_a_irq[1], gen_b_irq[1],
            gen_c_irq[1]});
        phase_mode <= 3'h0;
        count_down <= 3'h0;
        wr(5'h08, 16'h0000, 2'h1);
    endtask

    task automatic s_sync;
        wr(5'h18, 16'h0005, 2'h1);
        wr(5'h01, 16'h1234, 2'h3);
        rchk("ch2_preset", 5'h11, 16'h1234);
        rchk("sync_bits", 5'h18, 16'h0005);
        wr(5'h18, 16'h0000, 2'h1);
    endtask

    // ch0 stopped at the preset value, so the captured figure is exact
    task automatic s_capture;
        gen_is_capture <= 12'h002;
        gen_action <= 24'h000004;
        repeat (2) @(posedge ref_clk);
        capture_pin <= 12'h002;
        repeat (6) @(posedge ref_clk);
        rchk("ch0_cap_b", 5'h03, 16'h1234);
        rchk("ch0_cap_flag", 5'h00, 16'hDF42);
        chk("irq_cap", 16'h0001, {15'h0000, gen_b_irq[0]});
    endtask

    task automatic s_pin;
        pin_init_level <= 12'h001;
        pin_cfg_wr <= 12'h001;
        @(posedge ref_clk);
        pin_cfg_wr <= 12'h000;
        repeat (2) @(posedge ref_clk);
        chk("pin_init", 16'h0001, {15'h0000, timer_io_pin[0]});
    endtask

    // 12 ticks: period 5 until the buffer reloads gen A with 3, then period 4
    task automatic s_compare;
        gen_action <= 24'h000005;
        clear_sel <= 6'h31;
        buf_a_en <= 1'b1;
        wr(5'h18, 16'h0005, 2'h1);
        wr(5'h01, 16'h0000, 2'h3);
        wr(5'h02, 16'h0004, 2'h3);
        wr(5'h04, 16'h0003, 2'h3);
        wr(5'h18, 16'h0500, 2'h2);
        repeat (10) @(posedge ref_clk);
        wr(5'h18, 16'h0000, 2'h2);
        rchk("ch0_cnt_buf", 5'h01, 16'h0003);
        rchk("ch2_sync_clr", 5'h11, 16'h0003);
        rchk("ch0_gen_a_buf", 5'h02, 16'h0003);
        rchk("ch0_match_flag", 5'h00, 16'hDF43);
        chk("pin_hold", 16'h0000, {15'h0000, timer_io_pin[0]});
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        s_reset;
        s_enable;
        s_overflow;
        s_underflow;
        s_sync;
        s_capture;
        s_pin;
        s_compare;
        give_verdict;
    end
endmodule
`default_nettype wire
